// ---- hw/epc_event_pin_control.sv ----
module epc_event_pin_control
(
   input wire logic CLK,
   input wire logic RST,
   input wire epc_pkg::epc_wr_t REG_WR,
   input wire logic [7:0] CAL_FAIL_SET,
   input wire logic [7:0] CAL_FAIL_CLR,
   input wire logic DATA_READY,
   input wire logic CYCLE_DONE,
   input wire logic DIP_COND,
   input wire logic SWELL_COND,
   input wire logic CURRENT_COND,
   input wire logic POWER_COND,
   output logic [31:0] REG_RDATA,
   output logic [3:0] ALARM_STATUS,
   output logic ALERT_OUT_A,
   output logic ALERT_OUT_B
);
   import epc_pkg::*;

   // ************************************************************
   // register
   // ************************************************************
   epc_reg_t ctl, next_ctl;
   epc_evt_t clr_now, hold_v, sim_v, act;
   logic [31:0] wval;

   always_comb
   begin
      next_ctl = ctl;
      wval = REG_WR.wdata & EPC_WRITE_MASK;
      clr_now = '0;
      if (REG_WR.wr)
      begin
         next_ctl = epc_reg_t'(wval & EPC_STORE_MASK);
         clr_now = epc_clear_vec(wval[EPC_CLEAR_LSB +: 4]);
      end
      // calibration engine results win over a register write
      next_ctl.cal_fail = (next_ctl.cal_fail & ~CAL_FAIL_CLR) | CAL_FAIL_SET;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         ctl <= epc_reg_t'(EPC_RESET);
      else
         ctl <= next_ctl;
   end

   assign hold_v = epc_hold_sim_vec(ctl.hold);
   assign sim_v = epc_hold_sim_vec(ctl.sim);

   // ************************************************************
   // alarms
   // ************************************************************
   // sag and surge sampled on data-ready, current and power per cycle
   epc_alarm u_dip
   (
      .CLK(CLK),
      .RST(RST),
      .sample(DATA_READY | sim_v.dip),
      .cond(DIP_COND | sim_v.dip),
      .hold(hold_v.dip),
      .clear(clr_now.dip),
      .active(act.dip)
   );
   epc_alarm u_swell
   (
      .CLK(CLK),
      .RST(RST),
      .sample(DATA_READY | sim_v.swell),
      .cond(SWELL_COND | sim_v.swell),
      .hold(hold_v.swell),
      .clear(clr_now.swell),
      .active(act.swell)
   );
   epc_alarm u_current
   (
      .CLK(CLK),
      .RST(RST),
      .sample(CYCLE_DONE | sim_v.current),
      .cond(CURRENT_COND | sim_v.current),
      .hold(hold_v.current),
      .clear(clr_now.current),
      .active(act.current)
   );
   epc_alarm u_power
   (
      .CLK(CLK),
      .RST(RST),
      .sample(CYCLE_DONE | sim_v.power),
      .cond(POWER_COND | sim_v.power),
      .hold(hold_v.power),
      .clear(clr_now.power),
      .active(act.power)
   );

   // ************************************************************
   // pins and read-back
   // ************************************************************
   logic next_a, next_b;
   logic [31:0] next_rdata;
   logic [3:0] next_status;

   // a pin with any mapping shows its mapped alarms, else the manual level
   function automatic logic pin_level(input epc_evt_t map, input logic force_level, input epc_evt_t alarms);
      if (|map)
         pin_level = |(map & alarms);
      else
         pin_level = force_level;
   endfunction

   always_comb
   begin
      next_a = pin_level(ctl.map_a, ctl.force_level_a, act);
      next_b = pin_level(ctl.map_b, ctl.force_level_b, act);
      next_rdata = 32'(ctl);
      next_status = act;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ALERT_OUT_A <= 1'b0;
         ALERT_OUT_B <= 1'b0;
         REG_RDATA <= EPC_RESET;
         ALARM_STATUS <= 4'h0;
      end
      else
      begin
         ALERT_OUT_A <= next_a;
         ALERT_OUT_B <= next_b;
         REG_RDATA <= next_rdata;
         ALARM_STATUS <= next_status;
      end
   end

endmodule // epc_event_pin_control

// ---- hw/epc_pkg.sv ----
package epc_pkg;

   // ************************************************************
   // register layout
   // ************************************************************
   localparam int EPC_REG_W = 32;
   localparam logic [31:0] EPC_RESET = 32'h0000_0000;
   localparam int EPC_CAL_LSB = 24;
   localparam int EPC_MAP_B_LSB = 20;
   localparam int EPC_MAP_A_LSB = 16;
   localparam int EPC_FORCE_B_BIT = 15;
   localparam int EPC_FORCE_A_BIT = 14;
   localparam int EPC_CLEAR_LSB = 8;
   localparam int EPC_HOLD_LSB = 4;
   localparam int EPC_SIM_LSB = 0;
   // writable bits: everything except the unimplemented 13..12
   localparam logic [31:0] EPC_WRITE_MASK = 32'hffff_cfff;
   // clear bits are strobes and read back as zero
   localparam logic [31:0] EPC_STORE_MASK = 32'hffff_c0ff;

   // ************************************************************
   // event vector, common order: power, current, swell, dip
   // ************************************************************
   typedef struct packed {
      logic power;
      logic current;
      logic swell;
      logic dip;
   } epc_evt_t;

   typedef struct packed {
      logic [7:0] cal_fail;
      epc_evt_t map_b;
      epc_evt_t map_a;
      logic force_level_b;
      logic force_level_a;
      logic [1:0] unused;
      logic [3:0] clear;
      logic [3:0] hold;
      logic [3:0] sim;
   } epc_reg_t;

   typedef struct packed {
      logic wr;
      logic [31:0] wdata;
   } epc_wr_t;

   typedef enum logic [1:0] {EPC_IDLE, EPC_ACTIVE, EPC_HELD} epc_state_t;

   // clear bits 11..8 are current, power, swell, dip
   function automatic epc_evt_t epc_clear_vec(input logic [3:0] c);
      epc_clear_vec = '{power: c[2], current: c[3], swell: c[1], dip: c[0]};
   endfunction

   // hold and sim bits are swell, dip, power, current
   function automatic epc_evt_t epc_hold_sim_vec(input logic [3:0] c);
      epc_hold_sim_vec = '{power: c[1], current: c[0], swell: c[3], dip: c[2]};
   endfunction

endpackage

// ---- hw/epc_alarm.sv ----
// one alarm: follows or holds its condition
module epc_alarm
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic sample,
   input wire logic cond,
   input wire logic hold,
   input wire logic clear,
   output logic active
);
   import epc_pkg::*;

   epc_state_t state, next_state;

   always_comb
   begin
      next_state = state;
      case (state)
         EPC_IDLE:
         begin
            if (sample && cond)
               next_state = hold ? EPC_HELD : EPC_ACTIVE;
         end
         EPC_ACTIVE, EPC_HELD:
         begin
            // a new sample that still sees the condition beats the clear
            if (sample && cond)
               next_state = hold ? EPC_HELD : EPC_ACTIVE;
            else if (clear)
               next_state = EPC_IDLE;
            else if (hold)
               next_state = EPC_HELD;
            else if (sample)
               next_state = EPC_IDLE;
            else
               next_state = EPC_ACTIVE;
         end
         default: next_state = EPC_IDLE;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         state <= EPC_IDLE;
      else
         state <= next_state;
   end

   assign active = (state != EPC_IDLE);

endmodule // epc_alarm

// ---- verif/epc_event_pin_control_checker.sv ----
module epc_event_pin_control_checker (
   input wire logic CLK,
   input wire logic RST,
   input wire epc_pkg::epc_wr_t REG_WR,
   input wire logic [7:0] CAL_FAIL_SET,
   input wire logic DATA_READY,
   input wire logic DIP_COND,
   input wire logic [31:0] REG_RDATA,
   input wire logic [3:0] ALARM_STATUS,
   input wire logic ALERT_OUT_A,
   input wire logic ALERT_OUT_B
);
   timeunit 1ns;
   timeprecision 1ns;
   import epc_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   a_rst_clear: assert property (disable iff (1'b0) RST |=> REG_RDATA == 32'h0 && !ALERT_OUT_A)
      else $error("reset");
   a_hole_zero: assert property (REG_RDATA[13:8] == 6'h0)
      else $error("hole");
   a_write_back: assert property (REG_WR.wr ##1 !REG_WR.wr |=>
      (REG_RDATA[23:0] & 24'hffc0ff) == ($past(REG_WR.wdata[23:0], 2) & 24'hffc0ff)) else $error("wr");
   a_pin_a_map: assert property (ALERT_OUT_A ==
      (|REG_RDATA[19:16] ? |(REG_RDATA[19:16] & ALARM_STATUS) : REG_RDATA[14])) else $error("pa");
   a_pin_b_map: assert property (ALERT_OUT_B ==
      (|REG_RDATA[23:20] ? |(REG_RDATA[23:20] & ALARM_STATUS) : REG_RDATA[15])) else $error("pb");
   a_dip_set: assert property (DATA_READY && DIP_COND |-> ##2 ALARM_STATUS[0])
      else $error("dip");
   a_dip_drop: assert property ((DATA_READY && !DIP_COND) ##1 (!REG_RDATA[6] && !REG_RDATA[2]) |=>
      !ALARM_STATUS[0]) else $error("drop");
   a_cal_set: assert property (|CAL_FAIL_SET ##1 !REG_WR.wr |=>
      (REG_RDATA[31:24] & $past(CAL_FAIL_SET, 2)) == $past(CAL_FAIL_SET, 2)) else $error("cal");
   c_pin: cover property (ALERT_OUT_A);
   c_held: cover property (ALARM_STATUS[0] && REG_RDATA[6]);
   c_sim: cover property (ALERT_OUT_B && REG_RDATA[1]);
endmodule // epc_event_pin_control_checker
bind epc_event_pin_control epc_event_pin_control_checker i_chk (.CLK, .RST, .REG_WR, .CAL_FAIL_SET, .DATA_READY,
   .DIP_COND, .REG_RDATA, .ALARM_STATUS, .ALERT_OUT_A, .ALERT_OUT_B);

// ---- verif/epc_load_model.sv ----
// host interrupt input: counts rising edges of the event pin
module epc_load_model (
   input wire logic CLK,
   input wire logic RST,
   input wire logic ALERT_OUT_A,
   output int RISES
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last;
   always_ff @(posedge CLK)
   begin
      last <= RST ? 1'b0 : ALERT_OUT_A;
      RISES <= RST ? 0 : RISES + int'(ALERT_OUT_A && !last);
   end
endmodule // epc_load_model

// ---- verif/epc_event_pin_control_tb_top.sv ----
module epc_event_pin_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import epc_pkg::*;
   `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("Error %0t bad %h", $time, a); end end
   logic CLK = 0, RST = 1, DATA_READY = 0, CYCLE_DONE = 0, ALERT_OUT_A, ALERT_OUT_B;
   epc_wr_t REG_WR = '0;
   logic [7:0] CAL_FAIL_SET = 0, CAL_FAIL_CLR = 0;
   logic [3:0] cnd = 0, ALARM_STATUS;
   logic [31:0] REG_RDATA, exp;
   int fails = 0, samples_checked = 0, rises;
   integer seed = 32'h8504;
   initial forever #50 CLK = ~CLK;
   epc_event_pin_control i_epc_event_pin_control (.CLK, .RST, .REG_WR, .CAL_FAIL_SET, .CAL_FAIL_CLR, .DATA_READY,
      .CYCLE_DONE, .DIP_COND(cnd[0]), .SWELL_COND(cnd[1]), .CURRENT_COND(cnd[2]), .POWER_COND(cnd[3]), .REG_RDATA,
      .ALARM_STATUS, .ALERT_OUT_A, .ALERT_OUT_B);
   epc_load_model i_epc_load_model (.CLK, .RST, .ALERT_OUT_A, .RISES(rises));
   // pin shows mapped alarms, else the manual level
   function automatic logic pin(input logic [3:0] m, input logic f, input logic [3:0] al);
      return |m ? |(m & al) : f;
   endfunction
   task automatic chk(input logic [3:0] al);
      `CHK(REG_RDATA, exp)
      `CHK(ALARM_STATUS, al)
      `CHK(ALERT_OUT_A, pin(exp[19:16], exp[14], al))
      `CHK(ALERT_OUT_B, pin(exp[23:20], exp[15], al))
   endtask
   task automatic wr(input logic [31:0] w);
      @(negedge CLK) REG_WR = '{1'b1, w};
      @(negedge CLK) REG_WR.wr = 0;
      @(negedge CLK) exp = w & EPC_STORE_MASK;
   endtask
   task automatic ev(input logic [3:0] c, input logic d, input logic y);
      @(negedge CLK) cnd = c;
      {DATA_READY, CYCLE_DONE} = {d, y};
      @(negedge CLK) {DATA_READY, CYCLE_DONE} = 2'b00;
      repeat (2) @(negedge CLK);
   endtask
   task automatic summarize;
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      fails++;
      summarize;
   end
   initial
   begin
      repeat (6) @(negedge CLK);
      RST = 0;
      exp = 0;
      chk(0);
      repeat (8)
      begin
         wr($random(seed) & 32'hffff_fff0);
         chk(0);
      end
      wr(32'h0001_0000);
      ev(4'h1, 1, 0);
      chk(4'h1);
      ev(4'h0, 1, 0);
      chk(4'h0);
      wr(32'h0001_0040);
      ev(4'h1, 1, 0);
      ev(4'h0, 1, 0);
      chk(4'h1);
      wr(32'h0001_0140);
      repeat (2) @(negedge CLK);
      chk(4'h0);
      wr(32'h0080_8002);
      repeat (2) @(negedge CLK);
      chk(4'h8);
      wr(32'h0040_8000);
      ev(4'h4, 0, 1);
      chk(4'h4);
      @(negedge CLK) CAL_FAIL_SET = 8'h81;
      @(negedge CLK) CAL_FAIL_SET = 0;
      @(negedge CLK) CAL_FAIL_CLR = 8'h01;
      @(negedge CLK) CAL_FAIL_CLR = 0;
      repeat (2) @(negedge CLK);
      exp[31:24] = 8'h80;
      chk(4'h4);
      `CHK(rises != 0, 1'b1)
      summarize;
   end
endmodule // epc_event_pin_control_tb_top
